// >>> gripper_command_status_map.svh
// Register offsets, field positions, fault codes and timing figures of the gripper command map.
`ifndef GRIPPER_COMMAND_STATUS_MAP_SVH
`define GRIPPER_COMMAND_STATUS_MAP_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define OFS_MOTION_COMMAND    4'h0
`define OFS_INDICATOR_OPTION  4'h1
`define OFS_TARGET_POSITION   4'h3
`define OFS_TARGET_SPEED      4'h4
`define OFS_FORCE_LIMIT       4'h5
`define OFS_GRIPPER_STATE     4'h0
`define OFS_FAULT_CODE        4'h2
`define OFS_POSITION_ECHO     4'h3
`define OFS_MEASURED_POSITION 4'h4
`define OFS_MOTOR_CURRENT     4'h5

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define BIT_ACTIVATE          0
`define BIT_GOTO              3
`define BIT_AUTO_RELEASE      4
`define BIT_AUTO_RELEASE_DIR  5
`define BIT_INDICATOR_BYPASS  4
`define RST_ACTIVATE          1'b1
`define RST_BYTE              8'h00

// ----------------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------------
`define ACT_STATE_RESET       2'h0
`define ACT_STATE_RUNNING     2'h1
`define ACT_STATE_DONE        2'h3
`define OBJ_MOVING            2'h0
`define OBJ_CONTACT_OPENING   2'h1
`define OBJ_CONTACT_CLOSING   2'h2
`define OBJ_AT_TARGET         2'h3
`define FLT_NONE              4'h0
`define FLT_ACTION_DELAYED    4'h5
`define FLT_NOT_ACTIVATED     4'h7
`define FLT_OVER_TEMPERATURE  4'h8
`define FLT_NO_COMMUNICATION  4'h9
`define FLT_UNDERVOLTAGE      4'ha
`define FLT_RELEASE_RUNNING   4'hb
`define FLT_INTERNAL          4'hc
`define FLT_ACTIVATION        4'hd
`define FLT_OVERCURRENT       4'he
`define FLT_RELEASE_DONE      4'hf

// ----------------------------------------------------------------------------
// Timing and thresholds
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ           20000000
`define COMM_TIMEOUT_MS       1000
`define BLINK_HALF_MS         250
`define TEMP_HOT_C            8'd85
`define TEMP_COOL_C           8'd80

`endif

// >>> gripper_pkg.sv
// Types shared by the gripper command and status map.
package gripper_pkg;

	typedef enum logic [4:0] {
		ST_RESET      = 5'b00001,
		ST_ACTIVATING = 5'b00010,
		ST_READY      = 5'b00100,
		ST_RELEASE    = 5'b01000,
		ST_RELEASED   = 5'b10000
	} grip_state_e;

	typedef struct packed {
		logic       enable;
		logic       close;
		logic [7:0] target;
		logic [7:0] speed;
		logic [7:0] force_lim;
	} motion_cmd_s;

	typedef struct packed {
		logic       calib_done;
		logic       calib_fail;
		logic       stalled;
		logic       at_target;
		logic       limits_reached;
	} motion_status_s;

	typedef struct packed {
		logic       undervoltage;
		logic       internal_fault;
		logic       overcurrent;
	} fault_pins_s;

endpackage

// >>> gripper_command_status_map.sv
// Command and status register bank of the adaptive two-finger gripper controller.
//
// Function
// (RL1) Activate set starts calibration before anything else
// (RL2) Activate cleared resets gripper, clears faults
// (RL3) Controller keeps activate set during operation
// (RL4) After power loss require clear then set
// (RL5) Go-to set moves toward target; zero stops
// (RL6) No motion without go-to except routines
// (RL7) Auto-release drives to limits, then faults
// (RL8) Auto-release overrides all but activate
// (RL9) Release direction sampled when release starts
// (RL10) Indicator bypass forces both indicators off
// (RL11) Target byte: 0x00 open, 0xff closed
// (RL12) Speed live, never starts a motion
// (RL13) Force limits current; overrun stops, reports object
// (RL14) Status bit 0 echoes activate request
// (RL15) Status bit 3 echoes go-to request; the code echoes it only in ST_READY
// (RL16) Activation state: reset, running, done
// (RL17) Object state: moving, contact open/close, target
// (RL18) Priority faults 0x05 and 0x07, solid blue
// (RL19) Over-temperature fault with 85/80 hysteresis
// (RL20) No-communication fault after one second
// (RL21) Major faults blink, held until reactivation
// (RL22) No fault blue; boot shows blue and red
// (RL23) Controller writes zero to reserved bytes
// (RL24) Banks reached over the serial slave port
// (RL25) Fault byte high nibble reads zero
`timescale 1ns/1ps
`include "gripper_command_status_map.svh"

module gripper_command_status_map
	import gripper_pkg::*;
#(
	parameter int unsigned COMM_TIMEOUT_CYC = `COMM_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000),
	parameter int unsigned BLINK_HALF_CYC   = `BLINK_HALF_MS * (`CLK_FREQ_HZ / 1000)
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// Register bank port from the serial slave
	input  wire logic           wr_en,
	input  wire logic [3:0]     wr_addr,
	input  wire logic [7:0]     wr_data,
	input  wire logic           rd_en,
	input  wire logic [3:0]     rd_addr,
	output logic      [7:0]     rd_data,
	input  wire logic           frame_seen,
	// Motor drive side
	input  wire motion_status_s motor_status,
	input  wire logic [7:0]     measured_position,
	input  wire logic [7:0]     motor_current,
	output motion_cmd_s         motion_cmd,
	// Supervision
	input  wire fault_pins_s    fault_pins,
	input  wire logic [7:0]     temperature_c,
	input  wire logic           boot_done,
	// Indicators
	output logic                led_red,
	output logic                led_blue
);

	default clocking cb_main @(posedge clk); endclocking
	default disable iff (!rstn);

	// ------------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------------
	if (COMM_TIMEOUT_CYC < 2 || BLINK_HALF_CYC < 2) begin : g_param_check
		$error("Timeout and blink counts must be at least two cycles.");
	end

	// ------------------------------------------------------------------------
	// Pin filtering
	// ------------------------------------------------------------------------
	// A fault pin counts only once the second and third stages agree, which
	// rejects a single-cycle glitch at the cost of one more cycle of latency.
	localparam int NPIN = $bits(fault_pins_s);
	logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
	fault_pins_s     pins;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
					pin_s3_q[gi] <= 1'b0;
					pin_q[gi]    <= 1'b0;
				end else begin
					pin_s1_q[gi] <= fault_pins[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
					if (pin_s2_q[gi] == pin_s3_q[gi]) begin
						pin_q[gi] <= pin_s3_q[gi];
					end
				end
			end
		end
	endgenerate
	assign pins = fault_pins_s'(pin_q);

	// ------------------------------------------------------------------------
	// Output bank
	// ------------------------------------------------------------------------
	logic        act_q, goto_q, atr_q, dir_q, bypass_q, armed_q;
	logic [7:0]  target_q, speed_q, force_q;
	wire         wr_cmd  = wr_en && (wr_addr == `OFS_MOTION_COMMAND);
	wire         wr_opt  = wr_en && (wr_addr == `OFS_INDICATOR_OPTION);
	wire         wr_tgt  = wr_en && (wr_addr == `OFS_TARGET_POSITION);
	wire         act_clr = wr_cmd && !wr_data[`BIT_ACTIVATE];
	wire         act_rise = wr_cmd && wr_data[`BIT_ACTIVATE] && !act_q && armed_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			act_q    <= `RST_ACTIVATE;
			armed_q  <= 1'b0;
			goto_q   <= 1'b0;
			atr_q    <= 1'b0;
			dir_q    <= 1'b0;
			bypass_q <= 1'b0;
			target_q <= `RST_BYTE;
			speed_q  <= `RST_BYTE;
			force_q  <= `RST_BYTE;
		end else begin
			if (wr_cmd) begin
				act_q  <= wr_data[`BIT_ACTIVATE];
				goto_q <= wr_data[`BIT_GOTO];
				atr_q  <= wr_data[`BIT_AUTO_RELEASE];
				dir_q  <= wr_data[`BIT_AUTO_RELEASE_DIR];
			end
			if (act_clr) begin
				armed_q <= 1'b1; // RL4
			end
			if (wr_opt) begin
				bypass_q <= wr_data[`BIT_INDICATOR_BYPASS];
			end
			if (wr_tgt) begin
				target_q <= wr_data;
			end
			if (wr_en && wr_addr == `OFS_TARGET_SPEED) begin
				speed_q <= wr_data;
			end
			if (wr_en && wr_addr == `OFS_FORCE_LIMIT) begin
				force_q <= wr_data;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	grip_state_e st_q, st_d;
	logic        rel_close_q;
	wire         operable = act_q && armed_q;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_RESET:      st_d = act_rise ? ST_ACTIVATING : ST_RESET; // RL1
			ST_ACTIVATING: begin
				if (atr_q) begin
					st_d = ST_RELEASE; // RL8
				end else if (motor_status.calib_fail) begin
					st_d = ST_RESET;
				end else if (motor_status.calib_done) begin
					st_d = ST_READY;
				end
			end
			ST_READY:      st_d = atr_q ? ST_RELEASE : ST_READY; // RL8
			ST_RELEASE:    st_d = motor_status.limits_reached ? ST_RELEASED : ST_RELEASE; // RL7
			ST_RELEASED:   st_d = ST_RELEASED;
		endcase
		// The clearing write wins in its own cycle, and the rising write must not be
		// undone by the activate bit that still reads cleared in that cycle.
		if (act_clr || (!act_q && !act_rise)) begin
			st_d = ST_RESET; // RL2
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q        <= ST_RESET;
			rel_close_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_q != ST_RELEASE && st_d == ST_RELEASE) begin
				rel_close_q <= !dir_q; // RL9
			end
		end
	end

	// ------------------------------------------------------------------------
	// Object detection
	// ------------------------------------------------------------------------
	logic [1:0] obj_q;
	wire        closing    = target_q > measured_position; // RL11
	wire        goto_live  = (st_q == ST_READY) && goto_q;
	wire        goto_start = wr_cmd && wr_data[`BIT_GOTO] && !goto_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			obj_q <= `OBJ_MOVING;
		end else if (!goto_live || goto_start || wr_tgt) begin
			obj_q <= `OBJ_MOVING;
		end else if (obj_q == `OBJ_MOVING && motor_status.stalled) begin
			obj_q <= closing ? `OBJ_CONTACT_CLOSING : `OBJ_CONTACT_OPENING; // RL13 RL17
		end else if (obj_q == `OBJ_MOVING && motor_status.at_target) begin
			obj_q <= `OBJ_AT_TARGET; // RL17
		end
	end

	// ------------------------------------------------------------------------
	// Faults
	// ------------------------------------------------------------------------
	logic [3:0]  major_q, major_set, prio_q;
	logic        hot_q, silent_q;
	logic [31:0] comm_cnt_q;

	assign major_set = motor_status.calib_fail && st_q == ST_ACTIVATING ? `FLT_ACTIVATION :
		st_q == ST_RELEASED                         ? `FLT_RELEASE_DONE :
		st_q == ST_RELEASE                          ? `FLT_RELEASE_RUNNING :
		pins.overcurrent                            ? `FLT_OVERCURRENT :
		pins.internal_fault                         ? `FLT_INTERNAL :
		pins.undervoltage                           ? `FLT_UNDERVOLTAGE : `FLT_NONE;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			major_q    <= `FLT_NONE;
			prio_q     <= `FLT_NONE;
			hot_q      <= 1'b0;
			silent_q   <= 1'b0;
			comm_cnt_q <= '0;
		end else begin
			// A new major event in the clearing cycle is kept.
			if (major_set != `FLT_NONE && (major_q == `FLT_NONE || major_q == `FLT_RELEASE_RUNNING)) begin
				major_q <= major_set; // RL21
			end else if (act_clr || act_rise) begin
				major_q <= `FLT_NONE; // RL2 RL21
			end
			if ((goto_q || atr_q) && !operable) begin
				prio_q <= `FLT_NOT_ACTIVATED; // RL18
			end else if (goto_q && st_q == ST_ACTIVATING) begin
				prio_q <= `FLT_ACTION_DELAYED; // RL18
			end else begin
				prio_q <= `FLT_NONE;
			end
			if (temperature_c >= `TEMP_HOT_C) begin
				hot_q <= 1'b1; // RL19
			end else if (temperature_c < `TEMP_COOL_C) begin
				hot_q <= 1'b0; // RL19
			end
			if (frame_seen) begin
				comm_cnt_q <= '0;
				silent_q   <= 1'b0;
			end else if (comm_cnt_q >= COMM_TIMEOUT_CYC - 1) begin
				silent_q   <= 1'b1; // RL20
			end else begin
				comm_cnt_q <= comm_cnt_q + 32'd1;
			end
		end
	end

	wire [3:0] fault_code = (major_q != `FLT_NONE) ? major_q :
		hot_q    ? `FLT_OVER_TEMPERATURE :
		silent_q ? `FLT_NO_COMMUNICATION : prio_q;

	// ------------------------------------------------------------------------
	// Input bank read
	// ------------------------------------------------------------------------
	wire [1:0] act_state = (st_q == ST_ACTIVATING) ? `ACT_STATE_RUNNING :
		(st_q == ST_READY) ? `ACT_STATE_DONE : `ACT_STATE_RESET; // RL16
	wire       goto_echo = goto_q && (st_q == ST_READY); // RL15
	wire [7:0] state_byte = {obj_q, act_state, goto_echo, 2'b00, act_q}; // RL14
	wire [7:0] rd_mux = (rd_addr == `OFS_GRIPPER_STATE)     ? state_byte :
		(rd_addr == `OFS_FAULT_CODE)        ? {4'h0, fault_code} : // RL25
		(rd_addr == `OFS_POSITION_ECHO)     ? target_q :
		(rd_addr == `OFS_MEASURED_POSITION) ? measured_position :
		(rd_addr == `OFS_MOTOR_CURRENT)     ? motor_current : 8'h00;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= rd_mux; // RL24
		end
	end

	// ------------------------------------------------------------------------
	// Motion command
	// ------------------------------------------------------------------------
	// Go-to motion stops on any major fault; calibration and the release routine run regardless of it.
	wire motion_en = ((goto_live && obj_q == `OBJ_MOVING && major_q == `FLT_NONE) // RL5 RL6 RL13
		|| st_q == ST_ACTIVATING || st_q == ST_RELEASE); // RL6
	wire motion_close = (st_q == ST_RELEASE) ? rel_close_q : (st_q == ST_READY) && closing;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			motion_cmd <= '0;
		end else begin
			motion_cmd.enable    <= motion_en;
			motion_cmd.close     <= motion_close;
			motion_cmd.target    <= target_q;
			motion_cmd.speed     <= speed_q; // RL12
			motion_cmd.force_lim <= force_q; // RL13
		end
	end

	// ------------------------------------------------------------------------
	// Indicators
	// ------------------------------------------------------------------------
	logic [31:0] blink_cnt_q;
	logic        blink_q, booting_q;
	wire         is_major = fault_code >= `FLT_UNDERVOLTAGE;
	wire         is_minor = fault_code == `FLT_OVER_TEMPERATURE || fault_code == `FLT_NO_COMMUNICATION;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
			booting_q   <= 1'b1;
			led_red     <= 1'b0;
			led_blue    <= 1'b0;
		end else begin
			if (boot_done) begin
				booting_q <= 1'b0;
			end
			if (blink_cnt_q >= BLINK_HALF_CYC - 1) begin
				blink_cnt_q <= '0;
				blink_q     <= !blink_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 32'd1;
			end
			if (bypass_q) begin
				led_red  <= 1'b0; // RL10
				led_blue <= 1'b0; // RL10
			end else if (booting_q) begin
				led_red  <= 1'b1; // RL22
				led_blue <= 1'b1; // RL22
			end else if (is_major) begin
				led_red  <= blink_q; // RL21
				led_blue <= !blink_q; // RL21
			end else begin
				led_red  <= is_minor; // RL19 RL20
				led_blue <= !is_minor; // RL18 RL22
			end
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	property p_activate_start;
		act_rise && st_q == ST_RESET |=> st_q == ST_ACTIVATING;
	endproperty
	a_activate_start: assert property (p_activate_start) else $error("Activation did not start."); // RL1
	property p_clear_resets;
		act_clr && major_set == `FLT_NONE |=> st_q == ST_RESET && major_q == `FLT_NONE;
	endproperty
	a_clear_resets: assert property (p_clear_resets) else $error("Clearing activate left state or fault."); // RL2
	property p_power_loss;
		!armed_q |-> st_q == ST_RESET;
	endproperty
	a_power_loss: assert property (p_power_loss) else $error("Operation before clear and set."); // RL4
	property p_no_goto_no_motion;
		!goto_q && st_q == ST_READY && !atr_q |=> !motion_cmd.enable;
	endproperty
	a_no_goto_no_motion: assert property (p_no_goto_no_motion) else $error("Motion without go-to."); // RL6
	property p_release_overrides;
		atr_q && act_q && !act_clr && st_q == ST_READY |=> st_q == ST_RELEASE ##1 motion_cmd.enable;
	endproperty
	a_release_overrides: assert property (p_release_overrides) else $error("Auto-release did not take over."); // RL8
	property p_release_dir;
		st_q == ST_RELEASE |-> rel_close_q == (($past(st_q) == ST_RELEASE) ? $past(rel_close_q) : !$past(dir_q));
	endproperty
	a_release_dir: assert property (p_release_dir) else $error("Release direction not taken at start."); // RL9
	property p_bypass;
		bypass_q |=> !led_red && !led_blue;
	endproperty
	a_bypass: assert property (p_bypass) else $error("Indicators lit under bypass."); // RL10
	property p_echo;
		rd_en && rd_addr == `OFS_GRIPPER_STATE |=> rd_data[0] == $past(act_q) && rd_data[2:1] == 2'b00;
	endproperty
	a_echo: assert property (p_echo) else $error("Activate echo wrong."); // RL14
	property p_released_fault;
		st_q == ST_RELEASED |=> major_q == `FLT_RELEASE_DONE || !act_q;
	endproperty
	a_released_fault: assert property (p_released_fault) else $error("Release completion fault missing."); // RL7
	property p_hot;
		temperature_c >= `TEMP_HOT_C |=> hot_q;
	endproperty
	a_hot: assert property (p_hot) else $error("Over-temperature not flagged."); // RL19
	property p_high_nibble;
		rd_en && rd_addr == `OFS_FAULT_CODE |=> rd_data[7:4] == 4'h0;
	endproperty
	a_high_nibble: assert property (p_high_nibble) else $error("Fault high nibble not zero."); // RL25

endmodule

// >>> ctrl_master.sv
// Robot controller model that writes and reads the gripper register banks one byte at a time.
`timescale 1ns/1ps

module ctrl_master (
	// Clock
	input  wire logic       clk,
	// Register bank port
	output logic            wr_en,
	output logic [3:0]      wr_addr,
	output logic [7:0]      wr_data,
	output logic            rd_en,
	output logic [3:0]      rd_addr,
	input  wire logic [7:0] rd_data,
	output logic            frame_seen
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 4'h0;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_addr = 4'h0;
		frame_seen = 1'b0;
	end

	// Callers enter just after a rising edge and leave just after one, so strobes never double up.
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		wr_addr = a;
		wr_data = d;
		wr_en = 1'b1;
		frame_seen = 1'b1;
		@(posedge clk);
		#5;
		wr_en = 1'b0;
		frame_seen = 1'b0;
		// Released lines carry the inverse so a stale byte can never pass for a fresh one.
		wr_data = ~d;
		wr_addr = ~a;
		@(posedge clk);
		#5;
	endtask

	// Reads are not counted as frames, so the silence timer can be observed without disturbing it.
	task automatic get(input logic [3:0] a, output logic [7:0] d);
		rd_addr = a;
		rd_en = 1'b1;
		@(posedge clk);
		#5;
		rd_en = 1'b0;
		rd_addr = ~a;
		@(posedge clk);
		#5;
		d = rd_data;
	endtask

	task automatic ping();
		frame_seen = 1'b1;
		@(posedge clk);
		#5;
		frame_seen = 1'b0;
		@(posedge clk);
		#5;
	endtask
endmodule

// >>> gripper_command_status_map_bench.sv
// Self-checking bench for the gripper command and status map.
`timescale 1ns/1ps
`include "gripper_command_status_map.svh"

`define CHK(got, exp) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) begin \
			err_count++; \
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp); \
		end \
	end

module gripper_command_status_map_bench
	import gripper_pkg::*;
;
	logic           clk;
	logic           rstn;
	logic           wr_en;
	logic [3:0]     wr_addr;
	logic [7:0]     wr_data;
	logic           rd_en;
	logic [3:0]     rd_addr;
	logic [7:0]     rd_data;
	logic           frame_seen;
	motion_status_s ms;
	motion_cmd_s    motion_cmd;
	fault_pins_s    fp;
	logic [7:0]     temp;
	logic           boot_done;
	logic           led_red;
	logic           led_blue;
	logic [7:0]     rv;
	logic           blue0;
	int             err_count;
	int             checks_done;
	int             cycles;

	gripper_command_status_map #(.COMM_TIMEOUT_CYC(200), .BLINK_HALF_CYC(20)) gripper_command_status_map_inst (
		.clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data(rd_data), .frame_seen(frame_seen), .motor_status(ms),
		.measured_position(8'h10), .motor_current(8'h2a), .motion_cmd(motion_cmd), .fault_pins(fp),
		.temperature_c(temp), .boot_done(boot_done), .led_red(led_red), .led_blue(led_blue));

	ctrl_master ctrl_master_inst (
		.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data(rd_data), .frame_seen(frame_seen));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#5;
		end
	endtask

	task automatic put(input logic [3:0] a, input logic [7:0] d);
		ctrl_master_inst.put(a, d);
		tick(2);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		ctrl_master_inst.get(a, rv);
		`CHK(rv, exp)
	endtask

	task automatic drive(input logic [4:0] p);
		ms = motion_status_s'(p);
		tick(1);
		ms = '0;
		tick(2);
	endtask

	task automatic activate();
		put(`OFS_MOTION_COMMAND, 8'h00);
		put(`OFS_MOTION_COMMAND, 8'h01);
		drive(5'h10);
	endtask

	task automatic test_end(input string name);
		$display("test %s done, %0d mismatches so far", name, err_count);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		ms = '0;
		fp = '0;
		temp = 8'd25;
		boot_done = 1'b0;
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		#5;
		rstn = 1'b1;
		tick(1);
		`CHK({led_red, led_blue}, 2'b11)
		rdchk(`OFS_GRIPPER_STATE, 8'h01);
		put(`OFS_MOTION_COMMAND, 8'h09);
		rdchk(`OFS_GRIPPER_STATE, 8'h01);
		rdchk(`OFS_FAULT_CODE, 8'h07);
		`CHK(motion_cmd.enable, 1'b0)
		boot_done = 1'b1;
		tick(3);
		`CHK({led_red, led_blue}, 2'b01)
		put(`OFS_MOTION_COMMAND, 8'h00);
		rdchk(`OFS_GRIPPER_STATE, 8'h00);
		rdchk(`OFS_FAULT_CODE, 8'h00);
		`CHK({led_red, led_blue}, 2'b01)
		test_end("boot");

		put(`OFS_TARGET_POSITION, 8'hff);
		put(`OFS_TARGET_SPEED, 8'h80);
		put(`OFS_FORCE_LIMIT, 8'h40);
		put(`OFS_MOTION_COMMAND, 8'h01);
		rdchk(`OFS_GRIPPER_STATE, 8'h11);
		`CHK(motion_cmd.enable, 1'b1)
		put(`OFS_MOTION_COMMAND, 8'h09);
		rdchk(`OFS_FAULT_CODE, 8'h05);
		drive(5'h10);
		rdchk(`OFS_GRIPPER_STATE, 8'h39);
		`CHK(motion_cmd, motion_cmd_s'({2'b11, 24'hff8040}))
		put(`OFS_MOTION_COMMAND, 8'h01);
		ctrl_master_inst.get(`OFS_GRIPPER_STATE, rv);
		`CHK(rv[5:0], 6'h31)
		`CHK(motion_cmd.enable, 1'b0)
		put(`OFS_TARGET_SPEED, 8'h55);
		`CHK(motion_cmd.enable, 1'b0)
		`CHK(motion_cmd.speed, 8'h55)
		put(`OFS_MOTION_COMMAND, 8'h09);
		rdchk(`OFS_GRIPPER_STATE, 8'h39);
		drive(5'h02);
		rdchk(`OFS_GRIPPER_STATE, 8'hf9);
		rdchk(`OFS_POSITION_ECHO, 8'hff);
		rdchk(`OFS_MEASURED_POSITION, 8'h10);
		rdchk(`OFS_MOTOR_CURRENT, 8'h2a);
		put(`OFS_TARGET_POSITION, 8'h00);
		drive(5'h04);
		rdchk(`OFS_GRIPPER_STATE, 8'h79);
		`CHK(motion_cmd.enable, 1'b0)
		put(`OFS_TARGET_POSITION, 8'hff);
		rdchk(`OFS_GRIPPER_STATE, 8'h39);
		drive(5'h04);
		rdchk(`OFS_GRIPPER_STATE, 8'hb9);
		test_end("motion");

		for (int a = 6; a < 16; a++) put(a[3:0], 8'h00);
		put(4'h2, 8'haa);
		rdchk(4'h1, 8'h00);
		rdchk(`OFS_FAULT_CODE, 8'h00);
		for (int a = 6; a < 16; a++) rdchk(a[3:0], 8'h00);
		put(`OFS_INDICATOR_OPTION, 8'h10);
		`CHK({led_red, led_blue}, 2'b00)
		put(`OFS_INDICATOR_OPTION, 8'h00);
		`CHK({led_red, led_blue}, 2'b01)
		test_end("reserved and indicators");

		temp = 8'd85;
		tick(3);
		rdchk(`OFS_FAULT_CODE, 8'h08);
		`CHK({led_red, led_blue}, 2'b10)
		temp = 8'd80;
		tick(3);
		rdchk(`OFS_FAULT_CODE, 8'h08);
		temp = 8'd79;
		tick(3);
		rdchk(`OFS_FAULT_CODE, 8'h00);
		ctrl_master_inst.ping();
		tick(180);
		rdchk(`OFS_FAULT_CODE, 8'h00);
		tick(30);
		rdchk(`OFS_FAULT_CODE, 8'h09);
		`CHK({led_red, led_blue}, 2'b10)
		temp = 8'd90;
		tick(3);
		rdchk(`OFS_FAULT_CODE, 8'h08);
		temp = 8'd25;
		ctrl_master_inst.ping();
		tick(3);
		rdchk(`OFS_FAULT_CODE, 8'h00);
		test_end("minor faults");

		for (int i = 0; i < 3; i++) begin
			fp = fault_pins_s'(3'b100 >> i);
			tick(8);
			fp = '0;
			tick(8);
			rdchk(`OFS_FAULT_CODE, 8'h0a + 8'(2 * i));
			blue0 = led_blue;
			tick(20);
			`CHK(led_blue, ~blue0)
			put(`OFS_MOTION_COMMAND, 8'h00);
			rdchk(`OFS_FAULT_CODE, 8'h00);
			activate();
		end
		put(`OFS_MOTION_COMMAND, 8'h00);
		put(`OFS_MOTION_COMMAND, 8'h01);
		drive(5'h08);
		rdchk(`OFS_FAULT_CODE, 8'h0d);
		test_end("major faults");

		for (int d = 0; d < 2; d++) begin
			activate();
			// Direction goes out in the same byte as the request, never after it.
			put(`OFS_MOTION_COMMAND, 8'h19 | 8'(d << 5));
			ctrl_master_inst.get(`OFS_GRIPPER_STATE, rv);
			`CHK(rv[5:4], 2'b00)
			rdchk(`OFS_FAULT_CODE, 8'h0b);
			`CHK(motion_cmd.close, ~d[0])
			`CHK(motion_cmd.enable, 1'b1)
			drive(5'h01);
			rdchk(`OFS_FAULT_CODE, 8'h0f);
			`CHK(motion_cmd.enable, 1'b0)
			put(`OFS_MOTION_COMMAND, 8'h09);
			`CHK(motion_cmd.enable, 1'b0)
		end
		test_end("auto release");
		wrap_up();
	end
endmodule
